// ==== core/tcmd_pkg.sv ====
package tcmd_pkg;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_HZ     = 20_000_000;
    localparam int BP_TIME_US = 250;
    // A least time, exact at this rate, so no rounding is lost.
    localparam int BP_CYCLES  = BP_TIME_US * (CLK_HZ / 1_000_000);
    localparam int BP_CW      = 20;

    // ==========================================================
    // Host port map
    // ==========================================================
    localparam logic [13:0] ADDR_MAIN_CTL = 14'h0000;
    localparam logic [13:0] ADDR_INT_MODE = 14'h0001;
    localparam logic [1:0]  SEL_REGS      = 2'h0;
    localparam logic [1:0]  SEL_CM_L      = 2'h2;
    localparam logic [1:0]  SEL_CM_H      = 2'h3;
    localparam logic [15:0] REG_RST       = 16'h0000;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CR_VARIABLE_DELAY_ENABLE   = 4;
    localparam int CR_BPEN    = 3;
    localparam int IMS_START  = 0;
    localparam int IMS_PAT_LO = 1;
    localparam int CML_LAW    = 15;
    localparam int CML_VC     = 14;
    localparam int CML_SSA_LO = 9;
    localparam int CML_SCA_LO = 1;
    localparam int CML_MSG_LO = 3;
    localparam int CML_CMM    = 0;
    localparam int CMH_VOICE  = 0;
    localparam int CMH_INLAW  = 1;
    localparam int CMH_OUTLAW = 2;
    localparam int CMH_W      = 5;

    // ==========================================================
    // Data constants
    // ==========================================================
    localparam int         VAR_SAME_FRAME_MIN = 7;
    localparam logic [7:0] LAW_TOGGLE         = 8'h55;
    localparam logic [7:0] IDLE_BYTE          = 8'hFF;

    typedef enum logic [1:0] {BP_IDLE, BP_FILL, BP_HOLD} tcmd_bp_e;
endpackage

// ==== core/tcmd_fifo.sv ====
`timescale 1ns/1ps
module tcmd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   count;
    } tcmd_fifo_s;

    tcmd_fifo_s s, next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // ==========================================================
    // Handshake
    // ==========================================================
    // Ready depends only on fill level, so a full FIFO stalls the source.
    assign in_ready  = (s.count != (AW+1)'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data  = mem[s.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and level update.
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Storage has no reset; the level guards every read.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wp] <= in_data;
        end
    end
endmodule // tcmd_fifo

// ==== core/tcmd_delay_sel.sv ====
`timescale 1ns/1ps
module tcmd_delay_sel #(
    parameter int CH_W = 7
) (
    input  wire logic [CH_W-1:0] out_ch,
    input  wire logic [CH_W-1:0] src_ch,
    input  wire logic            var_sel,
    output logic [1:0]           frames_back
);
    import tcmd_pkg::*;

    logic signed [CH_W:0] diff;

    // ==========================================================
    // Frame bank choice
    // ==========================================================
    // Constant delay reads two frames back; variable reads the current
    // frame only when the source is far enough ahead to be stored already.
    always_comb begin
        diff = $signed({1'b0, out_ch}) - $signed({1'b0, src_ch});
        if (!var_sel) begin
            frames_back = 2'h2;
        end else if (diff > (CH_W+1)'(VAR_SAME_FRAME_MIN)) begin
            frames_back = 2'h0;
        end else begin
            frames_back = 2'h1;
        end
    end
endmodule // tcmd_delay_sel

// ==== core/tcmd_switch.sv ====
// Behaviour
// - With normal switching, bit 14 picks constant (low) or variable (high) delay.
// - Variable delay sends as early as possible, 8 channels to frame plus 7.
// - Variable: difference up to 7 waits one frame; above 7 same frame.
// - Constant delay is two frames plus output minus input channel.
// - Constant delay stays selectable even with variable delay enabled.
// - Low word 16 bits, high word 5 bits, one access each, unused bits zero.
// - Law enable low means no translation and high word ignored.
// - Normal mode takes source channel from bits 7..1, stream from 13..9.
// - Mode bit high gives message mode, outputting bits 10..3.
// - Law translation remains usable in message mode.
// - Programming writes pattern to bits 2..0, zeroes everything else.
// - A programming cycle lasts at least two frame periods.
// - Device clears start bit itself when programming finishes.
// - Clearing start or enable aborts programming at once.
`timescale 1ns/1ps
module tcmd_switch
    import tcmd_pkg::*;
#(
    parameter int CH_W      = 7,
    parameter int ST_W      = 5,
    parameter int FIFO_D    = 8,
    parameter int BP_CYC    = tcmd_pkg::BP_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 host_cs,
    input  wire logic                 host_wr,
    input  wire logic                 host_rd,
    input  wire logic [13:0]          host_addr,
    input  wire logic [15:0]          host_wdata,
    output logic [15:0]               host_rdata,
    output logic                      host_rvalid,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [7:0]           serial_input_stream,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [7:0]                serial_output_stream,
    output logic [CH_W+ST_W-1:0]      out_slot,
    output logic                      out_data_ok,
    output logic                      block_busy
);
    import tcmd_pkg::*;

    localparam int AW      = CH_W + ST_W;
    localparam int DEPTH   = 1 << AW;
    localparam int BP_LAST = ((BP_CYC > DEPTH) ? BP_CYC : DEPTH) - 1;
    localparam int FW      = AW + 9;

    typedef struct packed {
        logic [AW-1:0]    slot;
        logic [1:0]       bank;
        logic             var_en;
        logic             bp_en;
        logic             bp_start;
        logic [2:0]       pattern;
        tcmd_bp_e         bp_state;
        logic [AW-1:0]    bp_addr;
        logic [BP_CW-1:0] bp_cnt;
        logic [15:0]      rdata;
        logic             rvalid;
    } tcmd_state_s;

    tcmd_state_s s, next_s;

    logic [15:0]      cm_l [DEPTH];
    logic [CMH_W-1:0] cm_h [DEPTH];
    logic [7:0]       dmem [4*DEPTH];

    logic [15:0]      cml;
    logic [CMH_W-1:0] cmh;
    logic             channel_mode_bit, var_sel, law_on, byte_ok, advance, fifo_in_ready;
    logic [AW-1:0]    src_idx;
    logic [1:0]       frames_back, rd_bank;
    logic [7:0]       raw_byte, out_byte;
    logic             cm_wr_l, cm_wr_h, bp_wr;
    logic [FW-1:0]    fifo_out;

    // ==========================================================
    // Output channel decode
    // ==========================================================
    // Slot order is channel-major so every stream's channel n is sent in turn.
    assign cml     = cm_l[s.slot];
    assign cmh     = cm_h[s.slot];
    assign channel_mode_bit     = cml[CML_CMM];
    assign var_sel = !channel_mode_bit && cml[CML_VC];
    assign src_idx = {cml[CML_SCA_LO +: CH_W], cml[CML_SSA_LO +: ST_W]};
    assign law_on  = cml[CML_LAW];

    tcmd_delay_sel #(
        .CH_W (CH_W)
    ) u_delay (
        .out_ch      (s.slot[AW-1:ST_W]),
        .src_ch      (src_idx[AW-1:ST_W]),
        .var_sel     (var_sel),
        .frames_back (frames_back)
    );

    // Three frame banks rotate; going back two equals going forward one.
    always_comb begin
        unique case (frames_back)
            2'h0:    rd_bank = s.bank;
            2'h1:    rd_bank = (s.bank == 2'h0) ? 2'h2 : s.bank - 2'h1;
            default: rd_bank = (s.bank == 2'h2) ? 2'h0 : s.bank + 2'h1;
        endcase
    end

    // Byte selection and optional law translation.
    always_comb begin
        byte_ok = 1'b1;
        if (channel_mode_bit) begin
            raw_byte = cml[CML_MSG_LO +: 8];
        end else if (var_sel && !s.var_en) begin
            // Variable delay without the chip-wide enable has no valid data.
            raw_byte = IDLE_BYTE;
            byte_ok  = 1'b0;
        end else begin
            raw_byte = dmem[{rd_bank, src_idx}];
        end
        out_byte = raw_byte;
        // The high word matters only while translation is on, in any mode.
        if (law_on && cmh[CMH_VOICE] && (cmh[CMH_INLAW] != cmh[CMH_OUTLAW])) begin
            out_byte = raw_byte ^ LAW_TOGGLE;
        end
    end

    // ==========================================================
    // Output buffer
    // ==========================================================
    // A full buffer stalls the slot counter and the input together.
    assign advance  = in_valid && fifo_in_ready;
    assign in_ready = fifo_in_ready;

    tcmd_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({s.slot, byte_ok, out_byte}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out)
    );

    assign serial_output_stream = fifo_out[7:0];
    assign out_data_ok          = fifo_out[8];
    assign out_slot             = fifo_out[FW-1:9];

    // ==========================================================
    // Host port and block programming
    // ==========================================================
    assign bp_wr       = (s.bp_state == BP_FILL);
    assign cm_wr_l     = host_cs && host_wr && !bp_wr && (host_addr[13:12] == SEL_CM_L);
    assign cm_wr_h     = host_cs && host_wr && !bp_wr && (host_addr[13:12] == SEL_CM_H);
    assign host_rdata  = s.rdata;
    assign host_rvalid = s.rvalid;
    assign block_busy  = (s.bp_state != BP_IDLE);

    always_comb begin
        next_s        = s;
        next_s.rvalid = host_cs && host_rd;
        // Stream timing.
        if (advance) begin
            next_s.slot = s.slot + 1'b1;
            if (s.slot == AW'(DEPTH - 1)) begin
                next_s.bank = (s.bank == 2'h2) ? 2'h0 : s.bank + 2'h1;
            end
        end
        // Programming engine; an abort is checked before anything else.
        if ((s.bp_state != BP_IDLE) && (!s.bp_start || !s.bp_en)) begin
            next_s.bp_state = BP_IDLE;
        end else begin
            unique case (s.bp_state)
                BP_IDLE: begin
                    if (s.bp_start && s.bp_en) begin
                        next_s.bp_state = BP_FILL;
                        next_s.bp_addr  = '0;
                        next_s.bp_cnt   = '0;
                    end
                end
                BP_FILL: begin
                    next_s.bp_cnt  = s.bp_cnt + 1'b1;
                    next_s.bp_addr = s.bp_addr + 1'b1;
                    if (s.bp_addr == AW'(DEPTH - 1)) begin
                        next_s.bp_state = BP_HOLD;
                    end
                end
                BP_HOLD: begin
                    next_s.bp_cnt = s.bp_cnt + 1'b1;
                    // Holding out the full time keeps the cycle past two frames.
                    if (s.bp_cnt >= BP_CW'(BP_LAST)) begin
                        next_s.bp_state = BP_IDLE;
                        next_s.bp_start = 1'b0;
                    end
                end
            endcase
        end
        // Host writes come last so an explicit software write wins.
        if (host_cs && host_wr && (host_addr == ADDR_MAIN_CTL)) begin
            next_s.var_en = host_wdata[CR_VARIABLE_DELAY_ENABLE];
            next_s.bp_en  = host_wdata[CR_BPEN];
        end
        if (host_cs && host_wr && (host_addr == ADDR_INT_MODE)) begin
            next_s.bp_start = host_wdata[IMS_START];
            next_s.pattern  = host_wdata[IMS_PAT_LO +: 3];
        end
        // Read data; narrow words and unmapped addresses read zero.
        if (host_cs && host_rd) begin
            next_s.rdata = REG_RST;
            unique case (host_addr[13:12])
                SEL_CM_L: next_s.rdata = cm_l[host_addr[AW-1:0]];
                SEL_CM_H: next_s.rdata = {11'h000, cm_h[host_addr[AW-1:0]]};
                SEL_REGS: begin
                    if (host_addr == ADDR_MAIN_CTL) begin
                        next_s.rdata[CR_VARIABLE_DELAY_ENABLE] = s.var_en;
                        next_s.rdata[CR_BPEN]  = s.bp_en;
                    end else if (host_addr == ADDR_INT_MODE) begin
                        next_s.rdata[IMS_START]         = s.bp_start;
                        next_s.rdata[IMS_PAT_LO +: 3]   = s.pattern;
                    end
                end
                default: next_s.rdata = REG_RST;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.bp_state <= BP_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Memories: the fill engine owns the connection memory while it is in BP_FILL.
    always_ff @(posedge clk) begin
        if (advance) begin
            dmem[{s.bank, s.slot}] <= serial_input_stream;
        end
        if (bp_wr) begin
            cm_l[s.bp_addr] <= {13'h0000, s.pattern};
            cm_h[s.bp_addr] <= '0;
        end else begin
            if (cm_wr_l) begin
                cm_l[host_addr[AW-1:0]] <= host_wdata;
            end
            if (cm_wr_h) begin
                cm_h[host_addr[AW-1:0]] <= host_wdata[CMH_W-1:0];
            end
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [BP_CW-1:0] busy_len;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_len <= '0;
        end else begin
            busy_len <= block_busy ? busy_len + 1'b1 : '0;
        end
    end

    const_delay_bank_a: assert property (!channel_mode_bit && !cml[CML_VC] |-> frames_back == 2'h2)
        else $error("constant delay not two frames back");
    var_late_bank_a: assert property (var_sel && (s.slot[AW-1:ST_W] <= src_idx[AW-1:ST_W])
        |-> frames_back == 2'h1)
        else $error("variable delay wrong bank for non-positive difference");
    var_early_bank_a: assert property (var_sel
        && ({1'b0, s.slot[AW-1:ST_W]} > {1'b0, src_idx[AW-1:ST_W]} + (CH_W+1)'(7))
        |-> frames_back == 2'h0)
        else $error("variable delay did not use current frame");
    const_with_var_a: assert property (s.var_en && !channel_mode_bit && !cml[CML_VC] |-> byte_ok)
        else $error("constant delay lost with variable enable set");
    cmh_read_zero_a: assert property (host_cs && host_rd && host_addr[13:12] == SEL_CM_H
        |=> host_rvalid && host_rdata[15:CMH_W] == '0)
        else $error("high word read returned nonzero upper bits");
    // Frame banks are not reset, so an unfilled byte must still compare as itself.
    law_off_pass_a: assert property (!law_on |-> out_byte === raw_byte)
        else $error("translation applied with law enable low");
    msg_byte_out_a: assert property (channel_mode_bit && !law_on |-> out_byte == cml[10:3])
        else $error("message byte not output");
    fill_value_a: assert property (bp_wr
        |=> cm_l[$past(s.bp_addr)] == {13'h0000, $past(s.pattern)})
        else $error("fill pattern not written");
    // Completion clears start, so the bits are taken from the last busy cycle.
    fill_time_a: assert property ($fell(block_busy) && $past(s.bp_start) && $past(s.bp_en)
        |-> $past(busy_len) >= BP_CW'(BP_LAST))
        else $error("programming finished too soon");
    start_clear_a: assert property (s.bp_state == BP_HOLD && s.bp_cnt >= BP_CW'(BP_LAST)
        && s.bp_start && s.bp_en && !(host_cs && host_wr) |=> !s.bp_start && !block_busy)
        else $error("start bit not cleared after programming");
    abort_stop_a: assert property (block_busy && (!s.bp_start || !s.bp_en) |=> !block_busy)
        else $error("programming not aborted");

    fill_done_c: cover property ($fell(block_busy) && !s.bp_start);
    msg_out_c: cover property (advance && channel_mode_bit);
    var_same_frame_c: cover property (advance && var_sel && frames_back == 2'h0);
endmodule // tcmd_switch

// ==== testbench/tcmd_stream_peer.sv ====
`timescale 1ns/1ps
// ==========================================================
// Far-side stream source and sink
// ==========================================================
module tcmd_stream_peer (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       src_on,
    input  wire logic       snk_on,
    input  wire logic [7:0] next_byte,
    input  wire logic       in_ready,
    output logic            in_valid,
    output logic [7:0]      serial_input_stream,
    output logic            out_ready
);
    logic       go;
    logic       sink;
    logic       taken;
    logic [7:0] fresh;

    // Quiet lines at time zero.
    initial begin
        in_valid = 1'b0;
        serial_input_stream = 8'h00;
        out_ready = 1'b0;
    end

    // Controls are sampled on the edge and applied just after it.
    // An offered byte holds until taken; an idle line toggles so stale data never looks good.
    always @(posedge clk) begin
        go = src_on;
        sink = snk_on;
        fresh = next_byte;
        taken = in_valid && in_ready;
        #5;
        if (rst || !in_valid || taken) begin
            in_valid = go && !rst;
            serial_input_stream = go ? fresh : ~serial_input_stream;
        end
        out_ready = sink && !rst;
    end
endmodule // tcmd_stream_peer

// ==== testbench/tb_tdm_connection_memory_delay.sv ====
`timescale 1ns/1ps
module tb_tdm_connection_memory_delay;
    import tcmd_pkg::*;
    localparam int NS = 32;
    localparam int BP = 64;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        host_cs = 1'b0;
    logic        host_wr = 1'b0;
    logic        host_rd = 1'b0;
    logic [13:0] host_addr = 14'h0000;
    logic [15:0] host_wdata = 16'h0000;
    logic [15:0] host_rdata;
    logic        host_rvalid;
    logic        in_valid;
    logic        in_ready;
    logic [7:0]  serial_input_stream;
    logic        out_valid;
    logic        out_ready;
    logic [7:0]  serial_output_stream;
    logic [4:0]  out_slot;
    logic        out_data_ok;
    logic        block_busy;
    logic        src_on = 1'b0;
    logic        snk_on = 1'b0;
    logic        auto_on = 1'b0;
    logic        variable_delay_enable_now = 1'b0;
    logic [7:0]  next_byte = 8'h00;
    logic [31:0] st = 32'h416888CD;
    logic [15:0] cml [NS];
    logic [4:0]  cmh [NS];
    logic [7:0]  hist [16][NS];
    logic [15:0] q [$];
    int          in_cnt = 0;
    int          fail_count = 0;
    int          total_checks = 0;

    // ==========================================================
    // Design, far side and clock
    // ==========================================================
    tcmd_switch #(.CH_W(4), .ST_W(1), .FIFO_D(8), .BP_CYC(BP)) i_tcmd_switch (
        .clk(clk), .rst(rst), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .in_valid(in_valid), .in_ready(in_ready),
        .serial_input_stream(serial_input_stream), .out_valid(out_valid),
        .out_ready(out_ready), .serial_output_stream(serial_output_stream),
        .out_slot(out_slot), .out_data_ok(out_data_ok), .block_busy(block_busy));
    tcmd_stream_peer i_tcmd_stream_peer (
        .clk(clk), .rst(rst), .src_on(src_on), .snk_on(snk_on), .next_byte(next_byte),
        .in_ready(in_ready), .in_valid(in_valid),
        .serial_input_stream(serial_input_stream), .out_ready(out_ready));
    always #25 clk = ~clk;

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [31:0] rnd();
        st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
        return st;
    endfunction

    // Packs {skip, ok, 0, slot, byte} for the k-th taken slot.
    function automatic logic [15:0] expect_word(input int k);
        int s, f, sf, m, src, d;
        logic [15:0] w;
        logic [7:0] b;
        logic ok;
        s = k % NS;
        f = k / NS;
        w = cml[s];
        m = int'(w[CML_SCA_LO +: 4]);
        src = m * 2 + int'(w[CML_SSA_LO]);
        d = s / 2 - m;
        sf = w[CML_CMM] ? f : (!w[CML_VC] ? f - 2 : (d > VAR_SAME_FRAME_MIN ? f : f - 1));
        b = w[CML_CMM] ? w[CML_MSG_LO +: 8] : (sf >= 0 ? hist[sf][src] : 8'h00);
        if (w[CML_LAW] && cmh[s][CMH_VOICE] && cmh[s][CMH_INLAW] != cmh[s][CMH_OUTLAW]) begin
            b = b ^ LAW_TOGGLE;
        end
        ok = !(w[CML_VC] && !w[CML_CMM] && !variable_delay_enable_now);
        return {sf < 0 || !ok, ok, 1'b0, 5'(s), b};
    endfunction

    task automatic test_done();
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic give_up();
        fail_count++;
        test_done();
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0, got}, {15'h0, exp});
    endtask

    // One host cycle: strobe up for exactly one sampling edge.
    task automatic hwrite(input logic [13:0] a, input logic [15:0] d);
        @(posedge clk);
        #5;
        host_cs = 1'b1;
        host_wr = 1'b1;
        host_addr = a;
        host_wdata = d;
        @(posedge clk);
        #5;
        host_cs = 1'b0;
        host_wr = 1'b0;
    endtask

    task automatic rdchk(input logic [13:0] a, input logic [15:0] exp);
        int n;
        @(posedge clk);
        #5;
        host_cs = 1'b1;
        host_rd = 1'b1;
        host_addr = a;
        @(posedge clk);
        #5;
        host_cs = 1'b0;
        host_rd = 1'b0;
        for (n = 0; host_rvalid !== 1'b1 && n < 4; n++) @(posedge clk);
        if (n >= 4) give_up();
        chk16(host_rdata, exp);
    endtask

    task automatic wait_busy(input logic lvl, input int lim, output int n);
        for (n = 0; block_busy !== lvl && n < lim; n++) begin
            @(posedge clk);
            #5;
        end
        if (n >= lim) give_up();
    endtask

    // Stops the source and waits until every expected word came out.
    task automatic drain();
        int n;
        src_on = 1'b0;
        snk_on = 1'b1;
        for (n = 0; (q.size() != 0 || in_valid) && n < 500; n++) @(posedge clk);
        if (n >= 500) give_up();
        #5;
        chk1(out_valid, 1'b0);
    endtask

    task automatic run_frames(input int fr);
        int n;
        int goal;
        goal = in_cnt + fr * NS;
        auto_on = 1'b1;
        for (n = 0; in_cnt < goal && n < 5000; n++) @(posedge clk);
        if (n >= 5000) give_up();
        #5;
        auto_on = 1'b0;
        drain();
    endtask

    // Random bytes every cycle and, in free-running phases, random stalls on both sides.
    always @(posedge clk) begin
        logic [31:0] r;
        r = rnd();
        next_byte <= r[15:8];
        if (auto_on) begin
            src_on <= r[2:0] != 3'h0;
            snk_on <= r[5:3] != 3'h0;
        end
    end

    // Scoreboard: expectation is fixed when a slot is taken, compared when its word leaves.
    always @(posedge clk) begin
        logic [15:0] w;
        if (!rst && in_valid && in_ready) begin
            hist[in_cnt / NS][in_cnt % NS] = serial_input_stream;
            q.push_back(expect_word(in_cnt));
            in_cnt++;
        end
        if (!rst && out_valid && out_ready) begin
            if (q.size() == 0) give_up();
            w = q.pop_front();
            if (w[15]) begin
                w[7:0] = serial_output_stream;
            end
            chk16({3'h0, out_slot, serial_output_stream},
                  w & 16'h1FFF);
            chk1(out_data_ok, w[14]);
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        int n;
        logic [31:0] r;
        repeat (6) @(posedge clk);
        #5;
        rst = 1'b0;
        rdchk(ADDR_MAIN_CTL, REG_RST);
        rdchk(ADDR_INT_MODE, REG_RST);
        rdchk(14'h1000, 16'h0000);
        // Full block programming with pattern 5.
        hwrite(ADDR_MAIN_CTL, 16'h0008);
        hwrite(ADDR_INT_MODE, 16'h000B);
        wait_busy(1'b1, 4, n);
        wait_busy(1'b0, 200, n);
        chk1(n >= BP - 2 && n <= BP + 2, 1'b1);
        rdchk(ADDR_INT_MODE, 16'h000A);
        rdchk(ADDR_MAIN_CTL, 16'h0008);
        for (int i = 0; i < NS; i += 15) begin
            rdchk({SEL_CM_L, 12'(i)}, 16'h0005);
            rdchk({SEL_CM_H, 12'(i)}, 16'h0000);
        end
        // Abort through the start bit, then through the enable bit.
        hwrite(ADDR_INT_MODE, 16'h0007);
        wait_busy(1'b1, 4, n);
        hwrite(ADDR_INT_MODE, 16'h0006);
        wait_busy(1'b0, 3, n);
        hwrite(ADDR_MAIN_CTL, 16'h0008);
        hwrite(ADDR_INT_MODE, 16'h0003);
        wait_busy(1'b1, 4, n);
        hwrite(ADDR_MAIN_CTL, 16'h0000);
        wait_busy(1'b0, 3, n);
        rdchk(ADDR_INT_MODE, 16'h0003);
        hwrite(ADDR_INT_MODE, 16'h0000);
        rdchk({SEL_CM_L, 12'(NS - 1)}, 16'h0005);
        // Word widths of both memories.
        hwrite({SEL_CM_H, 12'h007}, 16'hFFFF);
        r = rnd();
        hwrite({SEL_CM_L, 12'h007}, r[15:0]);
        rdchk({SEL_CM_L, 12'h007}, r[15:0]);
        rdchk({SEL_CM_H, 12'h007}, 16'h001F);
        // Random connections, then the boundary cases of the delay table.
        for (int s = 0; s < NS; s++) begin
            r = rnd();
            cmh[s] = r[4:0];
            cml[s] = (r[6:5] == 2'h2) ? {r[12], 4'h0, r[20:13], 2'h0, 1'b1} :
                     {r[12], r[6:5] == 2'h1, 4'h0, r[11], 4'h0, r[10:7], 1'b0};
        end
        cml[31] = 16'h4000;
        cml[16] = 16'h4200;
        cml[14] = 16'h4000;
        cml[0] = 16'h021E;
        cml[2] = 16'h8619;
        cmh[2] = 5'h03;
        hwrite(ADDR_MAIN_CTL, 16'h0010);
        variable_delay_enable_now = 1'b1;
        for (int s = 0; s < NS; s++) begin
            hwrite({SEL_CM_H, 12'(s)}, {11'h0, cmh[s]});
            hwrite({SEL_CM_L, 12'(s)}, cml[s]);
        end
        // Fill the buffer against a stalled sink until it refuses.
        src_on = 1'b1;
        repeat (14) @(posedge clk);
        #5;
        chk1(in_ready, 1'b0);
        chk16(16'(q.size()), 16'h0008);
        drain();
        run_frames(6);
        hwrite(ADDR_MAIN_CTL, 16'h0000);
        variable_delay_enable_now = 1'b0;
        run_frames(2);
        test_done();
    end
endmodule // tb_tdm_connection_memory_delay
